/* test/qhsc_enc_model.sv */
// incremental encoder model driving count and phase-z pins
`timescale 1ns/1ps
module qhsc_enc_model (
    input  wire logic       clock,
    output logic      [3:0] enc_up,
    output logic      [3:0] enc_down,
    output logic      [3:0] enc_z
);
    initial begin
        enc_up = 4'h0;
        enc_down = 4'h0;
        enc_z = 4'h0;
    end
    // kind 0 up, 1 down, 2 phase-z; levels held 3 cycles so the synchroniser sees each one
    task automatic pulse(input int ch, input int kind, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            case (kind)
                0: enc_up[ch] <= 1'b1;
                1: enc_down[ch] <= 1'b1;
                default: enc_z[ch] <= 1'b1;
            endcase
            repeat (3) @(posedge clock);
            enc_up <= 4'h0;
            enc_down <= 4'h0;
            enc_z <= 4'h0;
            repeat (3) @(posedge clock);
        end
        repeat (4) @(posedge clock);
    endtask : pulse
endmodule : qhsc_enc_model

/* test/qhsc_top_bench.sv */
// self-checking bench for the quad counter word interface
`timescale 1ns/1ps
module qhsc_top_bench
    import qhsc_pkg::*;
;
    logic              clock = 1'b0;
    logic              resetn = 1'b0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [ADDR_W-1:0] addr = 5'h00;
    logic [15:0]       wdata = 16'h0000;
    logic [15:0]       rdata;
    logic [3:0]        enc_up;
    logic [3:0]        enc_down;
    logic [3:0]        enc_z;
    logic [3:0]        ext_out;
    logic              rd_seen = 1'b0;
    logic [31:0]       note_q[$];
    logic [31:0]       note;
    logic [15:0]       r;
    int                fail_count = 0;
    int                num_checks = 0;
    int                seed = 32'ha6f14c28;

    qhsc_top dut_u (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .enc_up(enc_up), .enc_down(enc_down), .enc_z(enc_z),
        .ext_out(ext_out));
    qhsc_enc_model enc_u (.clock(clock), .enc_up(enc_up), .enc_down(enc_down), .enc_z(enc_z));

    initial begin
        forever #25 clock = ~clock;
    end

    task check(input logic [15:0] seen, input logic [15:0] expv);
        num_checks++;
        if (seen !== expv) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_chk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        note_q.push_back({m, e & m});
        @(posedge clock);
        rd <= 1'b0;
    endtask : rd_chk

    // write then read back in the very next cycle
    task wr_rd(input logic [4:0] a, input logic [15:0] d, input logic [15:0] m);
        wr_reg(a, d);
        rd <= 1'b1;
        note_q.push_back({16'hffff, d & m});
        @(posedge clock);
        rd <= 1'b0;
    endtask : wr_rd

    task ext_chk(input logic [3:0] e);
        repeat (3) @(posedge clock);
        #1;
        check({12'h000, ext_out}, {12'h000, e});
    endtask : ext_chk

    // read data stand only in the cycle after the strobe
    always @(posedge clock) begin
        if (rd_seen) begin
            if (note_q.size() == 0) begin
                fail_count++;
                $display("MISMATCH at %0t: read data with no expectation", $time);
            end else begin
                note = note_q.pop_front();
                check(rdata & note[31:16], note[15:0]);
            end
        end
        rd_seen <= rd;
    end

    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        $display("MISMATCH at %0t: run did not finish", $time);
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        rd_chk(ADDR_CTRL, 16'hffff, 16'h0000);
        rd_chk(ADDR_FORCE, 16'hffff, 16'h0000);
        rd_chk(ADDR_SETUP, 16'hffff, 16'h0000);
        rd_chk(5'h1f, 16'hffff, 16'h0000);
        wr_reg(ADDR_STATUS_BASE, 16'hffff);
        rd_chk(ADDR_STATUS_BASE, 16'hffff, 16'h1000);
        for (int i = 0; i < 4; i++) begin
            r = 16'($random(seed)) & 16'hf000;
            wr_rd(ADDR_CTRL, r, CTL_MASK);
            for (int k = 0; k < 4; k++) begin
                rd_chk(5'(ADDR_STATUS_BASE + k), 16'h1000, {3'h0, ~r[12 + k], 12'h000});
            end
        end
        wr_rd(ADDR_CTRL, 16'h0000, CTL_MASK);
        wr_rd(ADDR_FORCE, 16'h000f, FRC_MASK);
        ext_chk(4'h0);
        wr_rd(ADDR_FORCE, 16'h0015, FRC_MASK);
        ext_chk(4'h5);
        wr_rd(ADDR_FORCE, 16'h0000, FRC_MASK);
        ext_chk(4'h0);
        // binary underflow wraps to all ones and raises the flag
        enc_u.pulse(0, 1, 1);
        rd_chk(ADDR_VALUE_BASE, 16'hffff, 16'hffff);
        rd_chk(5'h01, 16'hffff, 16'hffff);
        rd_chk(ADDR_STATUS_BASE, 16'h4000, 16'h4000);
        wr_rd(ADDR_SETUP, 16'h0001, SETUP_MASK);
        wr_reg(ADDR_CTRL, 16'h0001);
        rd_chk(ADDR_VALUE_BASE, 16'hffff, 16'h0000);
        rd_chk(5'h01, 16'hffff, 16'h0000);
        rd_chk(ADDR_STATUS_BASE, 16'h4000, 16'h0000);
        enc_u.pulse(0, 0, 12);
        rd_chk(ADDR_VALUE_BASE, 16'hffff, 16'h0012);
        wr_reg(ADDR_CTRL, 16'h0001);
        rd_chk(ADDR_VALUE_BASE, 16'hffff, 16'h0012);
        wr_reg(ADDR_CTRL, 16'h1001);
        enc_u.pulse(0, 0, 3);
        rd_chk(ADDR_VALUE_BASE, 16'hffff, 16'h0012);
        wr_reg(ADDR_CTRL, 16'h0000);
        enc_u.pulse(3, 1, 1);
        rd_chk(5'h06, 16'hffff, 16'h9999);
        rd_chk(5'h07, 16'hffff, 16'h9999);
        // comparison on counter 1 at a present value of 3
        wr_reg(ADDR_TABLE_LO, 16'h0003);
        wr_reg(ADDR_TABLE_HI, 16'h02a5);
        wr_reg(ADDR_TABLE_CMD, 16'h0005);
        wr_reg(ADDR_CTRL, 16'h0200);
        rd_chk(5'h09, 16'h2000, 16'h2000);
        enc_u.pulse(1, 0, 3);
        rd_chk(5'h09, 16'h0fff, 16'h02a5);
        ext_chk(4'h2);
        wr_reg(ADDR_CTRL, 16'h0000);
        rd_chk(5'h09, 16'h2000, 16'h0000);
        // a target that is not bcd flags a set-value error until a valid load
        wr_reg(ADDR_TABLE_LO, 16'h00a0);
        wr_reg(ADDR_TABLE_CMD, 16'h0006);
        rd_chk(5'h0a, 16'h8000, 16'h8000);
        wr_reg(ADDR_TABLE_LO, 16'h0010);
        wr_reg(ADDR_TABLE_CMD, 16'h0006);
        rd_chk(5'h0a, 16'h8000, 16'h0000);
        // phase-z reset only while its enable bit is set
        wr_rd(ADDR_SETUP, 16'h0011, SETUP_MASK);
        enc_u.pulse(0, 2, 1);
        rd_chk(ADDR_VALUE_BASE, 16'hffff, 16'h0012);
        wr_reg(ADDR_CTRL, 16'h0001);
        enc_u.pulse(0, 0, 2);
        enc_u.pulse(0, 2, 1);
        rd_chk(ADDR_VALUE_BASE, 16'hffff, 16'h0000);
        rd_chk(5'h01, 16'hffff, 16'h0000);
        repeat (4) @(posedge clock);
        print_verdict();
    end
endmodule : qhsc_top_bench

/* test/qhsc_top_sva.sv */
// assertion checker for the counter word interface
`timescale 1ns/1ps
module qhsc_top_sva
    import qhsc_pkg::*;
(
    input wire logic              clock,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [15:0]       wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [15:0]       rdata,
    input wire logic [3:0]        enc_up,
    input wire logic [3:0]        enc_down,
    input wire logic [3:0]        enc_z,
    input wire logic [3:0]        ext_out
);
    logic [15:0] ctl_r;
    logic [4:0]  frc_r;
    logic        stop_now;
    // shadows of the two control words, so flags can be tied to what was written
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctl_r <= ZERO16;
            frc_r <= 5'h00;
        end else if (wr && addr == ADDR_CTRL) begin
            ctl_r <= wdata;
        end else if (wr && addr == ADDR_FORCE) begin
            frc_r <= wdata[4:0];
        end
    end
    assign stop_now = ctl_r[CTL_STOP_LSB + addr[1:0]];
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence wr_rd_s(logic [4:0] a);
        (wr && addr == a) ##1 (rd && addr == a);
    endsequence
    idle_rdata_a: assert property (!rd |=> rdata == ZERO16)
        else $error("read data not zero outside a read");
    reset_quiet_a: assert property ($rose(resetn) |-> rdata == ZERO16 && ext_out == 4'h0)
        else $error("outputs not quiet after reset");
    ctrl_readback_a: assert property (wr_rd_s(ADDR_CTRL) |=>
        rdata == ($past(wdata, 2) & CTL_MASK))
        else $error("control word readback wrong");
    force_readback_a: assert property (wr_rd_s(ADDR_FORCE) |=>
        rdata == ($past(wdata, 2) & FRC_MASK))
        else $error("force word readback wrong");
    setup_readback_a: assert property (wr_rd_s(ADDR_SETUP) |=>
        rdata == ($past(wdata, 2) & SETUP_MASK))
        else $error("setup word readback wrong");
    unmapped_zero_a: assert property ((rd && addr > ADDR_TABLE_CMD) |=> rdata == ZERO16)
        else $error("unmapped read not zero");
    run_flag_a: assert property ((rd && addr[4:2] == 3'b010) |=>
        rdata[ST_RUN] == !$past(stop_now))
        else $error("running flag disagrees with stop bit");
    force_on_a: assert property (frc_r[FRC_EN] |=>
        (ext_out & $past(frc_r[3:0])) == $past(frc_r[3:0]))
        else $error("forced output not on");
endmodule : qhsc_top_sva
bind qhsc_top qhsc_top_sva chk_u (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .enc_up(enc_up), .enc_down(enc_down), .enc_z(enc_z),
    .ext_out(ext_out));

/* verilog/qhsc_pkg.sv */
// package for the quad high-speed counter status and control words
package qhsc_pkg;
    localparam int NUM_CNT = 4;
    localparam int ADDR_W  = 5;
    localparam int WORD_W  = 16;

    // word addresses, in the order of the controller's word map
    localparam logic [4:0] ADDR_VALUE_BASE  = 5'h00;  // low/high pairs at 0..7
    localparam logic [4:0] ADDR_STATUS_BASE = 5'h08;  // status words at 8..11
    localparam logic [4:0] ADDR_CTRL        = 5'h0c;
    localparam logic [4:0] ADDR_FORCE       = 5'h0d;
    localparam logic [4:0] ADDR_SETUP       = 5'h0e;
    localparam logic [4:0] ADDR_TABLE_LO    = 5'h0f;
    localparam logic [4:0] ADDR_TABLE_HI    = 5'h10;
    localparam logic [4:0] ADDR_TABLE_CMD   = 5'h11;

    // status word fields
    localparam int ST_INT_LSB = 0;
    localparam int ST_EXT_LSB = 8;
    localparam int ST_RUN     = 12;
    localparam int ST_CMP     = 13;
    localparam int ST_OVF     = 14;
    localparam int ST_SVERR   = 15;

    // control word fields
    localparam int CTL_RST_LSB  = 0;
    localparam int CTL_CMP_LSB  = 8;
    localparam int CTL_STOP_LSB = 12;
    localparam logic [15:0] CTL_MASK = 16'hff0f;

    // force word fields
    localparam int FRC_EN = 4;
    localparam logic [15:0] FRC_MASK = 16'h001f;

    // setup word: bit 0 selects bcd, bits 4..7 select phase-z reset mode per counter
    localparam int SETUP_BCD     = 0;
    localparam int SETUP_ZMODE_LSB = 4;
    localparam logic [15:0] SETUP_MASK = 16'h00f1;

    // table command word: bits 1:0 counter, bit 2 load strobe; entry data word layout
    localparam int TCMD_LOAD = 2;
    localparam logic [15:0] TABLE_HI_MASK = 16'h0fff;

    localparam logic [31:0] MAX_BIN = 32'hffffffff;
    localparam logic [31:0] MAX_BCD = 32'h99999999;
    localparam logic [31:0] ZERO32  = 32'h00000000;
    localparam logic [15:0] ZERO16  = 16'h0000;

    typedef struct packed {
        logic        load;
        logic [1:0]  cnt;
        logic [31:0] target;
        logic [7:0]  int_pat;
        logic [3:0]  ext_pat;
    } qhsc_entry_s;

    typedef struct packed {
        logic [3:0] up;
        logic [3:0] down;
        logic [3:0] zpulse;
    } qhsc_enc_s;
endpackage : qhsc_pkg

/* verilog/qhsc_top.sv */
// four-channel high-speed counter with controller word interface
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
module qhsc_top
    import qhsc_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [15:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [15:0]       rdata,
    input  wire logic [3:0]        enc_up,
    input  wire logic [3:0]        enc_down,
    input  wire logic [3:0]        enc_z,
    output logic      [3:0]        ext_out
);
    // pin synchronisers
    qhsc_enc_s enc_s1_r, enc_s2_r, enc_s3_r;
    qhsc_enc_s enc_s1_nxt;

    // software-visible words
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [15:0] force_r, force_nxt;
    logic [15:0] setup_r, setup_nxt;
    logic [15:0] tlo_r, tlo_nxt;
    logic [15:0] thi_r, thi_nxt;

    // output stages
    logic [15:0] rdata_nxt;
    logic [3:0]  ext_out_nxt;

    // present values, one 32-bit word per counter
    logic [31:0] count_r  [NUM_CNT];
    logic [31:0] count_nxt[NUM_CNT];

    // comparison table, one entry per counter
    logic [31:0] target_r  [NUM_CNT];
    logic [31:0] target_nxt[NUM_CNT];
    logic [7:0]  intp_r  [NUM_CNT];
    logic [7:0]  intp_nxt[NUM_CNT];
    logic [3:0]  extp_r  [NUM_CNT];
    logic [3:0]  extp_nxt[NUM_CNT];
    logic [3:0]  tvalid_r, tvalid_nxt;

    // status flags
    logic [3:0]  cmp_r, cmp_nxt;
    logic [3:0]  ovf_r, ovf_nxt;
    logic [3:0]  sverr_r, sverr_nxt;
    logic [15:0] status_word[NUM_CNT];

    // last met comparison patterns, held until the next match
    logic [7:0]  res_int_r  [NUM_CNT];
    logic [7:0]  res_int_nxt[NUM_CNT];
    logic [3:0]  res_ext_r  [NUM_CNT];
    logic [3:0]  res_ext_nxt[NUM_CNT];

    // shared helpers
    qhsc_entry_s entry;
    logic [15:0] ctrl_prev;
    logic [31:0] limit;

    assign enc_s1_nxt = '{up: enc_up, down: enc_down, zpulse: enc_z};
    assign ctrl_prev  = ctrl_r;
    assign limit      = setup_r[SETUP_BCD] ? MAX_BCD : MAX_BIN;

    // table load command, gathered once for all counters
    always_comb begin
        entry.load    = wr && (addr == ADDR_TABLE_CMD) && wdata[TCMD_LOAD];
        entry.cnt     = wdata[1:0];
        entry.target  = {ZERO16, tlo_r};
        entry.int_pat = thi_r[7:0];
        entry.ext_pat = thi_r[11:8];
    end

    // register writes
    always_comb begin
        ctrl_nxt  = ctrl_r;
        force_nxt = force_r;
        setup_nxt = setup_r;
        tlo_nxt   = tlo_r;
        thi_nxt   = thi_r;

        // read-only and unmapped addresses fall to the default and are ignored
        if (wr) begin
            case (addr)
                ADDR_CTRL:     ctrl_nxt  = wdata & CTL_MASK;
                ADDR_FORCE:    force_nxt = wdata & FRC_MASK;
                ADDR_SETUP:    setup_nxt = wdata & SETUP_MASK;
                ADDR_TABLE_LO: tlo_nxt   = wdata;
                ADDR_TABLE_HI: thi_nxt   = wdata;
                default:       ;
            endcase
        end
    end

    // bcd digit step and check helpers
    function automatic logic [31:0] inc_val(input logic [31:0] v, input logic bcd);
        logic [31:0] r;
        logic        c;

        r = v;
        c = 1'b1;

        if (!bcd) begin
            r = v + 32'h1;
        end else begin
            for (int d = 0; d < 8; d++) begin
                if (c) begin
                    if (v[d*4 +: 4] >= 4'h9) begin
                        r[d*4 +: 4] = 4'h0;
                    end else begin
                        r[d*4 +: 4] = v[d*4 +: 4] + 4'h1;
                        c = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : inc_val

    function automatic logic [31:0] dec_val(input logic [31:0] v, input logic bcd);
        logic [31:0] r;
        logic        b;

        r = v;
        b = 1'b1;

        if (!bcd) begin
            r = v - 32'h1;
        end else begin
            for (int d = 0; d < 8; d++) begin
                if (b) begin
                    if (v[d*4 +: 4] == 4'h0) begin
                        r[d*4 +: 4] = 4'h9;
                    end else begin
                        r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                        b = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : dec_val

    function automatic logic bad_bcd(input logic [31:0] v);
        logic e;

        e = 1'b0;
        for (int d = 0; d < 8; d++) begin
            if (v[d*4 +: 4] > 4'h9) begin
                e = 1'b1;
            end
        end

        return e;
    endfunction : bad_bcd

    // per-counter logic
    genvar g;
    generate
        for (g = 0; g < NUM_CNT; g++) begin : g_cnt
            logic up_q, dn_q, z_q, z_prev;
            logic sw_rst, z_rst, do_rst, hit;

            // each counting pin acts on its rising edge only
            assign up_q   = enc_s2_r.up[g] && !enc_s3_r.up[g];
            assign dn_q   = enc_s2_r.down[g] && !enc_s3_r.down[g];
            assign z_q    = enc_s2_r.zpulse[g];
            assign z_prev = enc_s3_r.zpulse[g];
            // mode bit 1 = phase-z edge while the software bit is set, 0 = software only
            assign z_rst  = setup_r[SETUP_ZMODE_LSB + g] && ctrl_r[CTL_RST_LSB + g]
                            && z_q && !z_prev;
            assign sw_rst = !setup_r[SETUP_ZMODE_LSB + g] && ctrl_nxt[CTL_RST_LSB + g]
                            && !ctrl_prev[CTL_RST_LSB + g];

            assign do_rst = z_rst || sw_rst;
            assign hit    = tvalid_r[g] && cmp_r[g] && (count_r[g] == target_r[g]);

            always_comb begin
                count_nxt[g]   = count_r[g];
                target_nxt[g]  = target_r[g];
                intp_nxt[g]    = intp_r[g];
                extp_nxt[g]    = extp_r[g];
                tvalid_nxt[g]  = tvalid_r[g];
                cmp_nxt[g]     = cmp_r[g];
                ovf_nxt[g]     = ovf_r[g];
                sverr_nxt[g]   = sverr_r[g];
                res_int_nxt[g] = res_int_r[g];
                res_ext_nxt[g] = res_ext_r[g];

                if (do_rst) begin
                    count_nxt[g] = ZERO32;
                    ovf_nxt[g]   = 1'b0;
                end else if (!ctrl_r[CTL_STOP_LSB + g]) begin
                    // a step on both pins at once cancels out
                    if (up_q && !dn_q) begin
                        // wraps at the limit; the flag sticks until this counter resets
                        if (count_r[g] == limit) begin
                            count_nxt[g] = ZERO32;
                            ovf_nxt[g]   = 1'b1;
                        end else begin
                            count_nxt[g] = inc_val(count_r[g], setup_r[SETUP_BCD]);
                        end
                    end else if (dn_q && !up_q) begin
                        if (count_r[g] == ZERO32) begin
                            count_nxt[g] = limit;
                            ovf_nxt[g]   = 1'b1;
                        end else begin
                            count_nxt[g] = dec_val(count_r[g], setup_r[SETUP_BCD]);
                        end
                    end
                end

                // table entry load: high word carries patterns above a 16-bit target
                if (entry.load && entry.cnt == 2'(g)) begin
                    target_nxt[g] = entry.target;
                    intp_nxt[g]   = entry.int_pat;
                    extp_nxt[g]   = entry.ext_pat;
                    tvalid_nxt[g] = 1'b1;
                    // in bcd mode a target with a digit above 9 is a set-value error
                    sverr_nxt[g]  = setup_r[SETUP_BCD] && bad_bcd({ZERO16, tlo_r});
                    if (setup_r[SETUP_BCD] && bad_bcd({ZERO16, tlo_r})) begin
                        tvalid_nxt[g] = 1'b0;
                    end
                end

                // comparison runs from a 0 to 1 edge of its bit until a 1 to 0 edge
                if (ctrl_nxt[CTL_CMP_LSB + g] && !ctrl_prev[CTL_CMP_LSB + g]) begin
                    cmp_nxt[g] = 1'b1;
                end
                if (ctrl_prev[CTL_CMP_LSB + g] && !ctrl_nxt[CTL_CMP_LSB + g]) begin
                    cmp_nxt[g] = 1'b0;
                end

                // a match is level-sensitive: a held value reloads the same patterns
                if (hit) begin
                    res_int_nxt[g] = intp_r[g];
                    res_ext_nxt[g] = extp_r[g];
                end
            end

            // status word of this counter, unused bits read zero
            always_comb begin
                status_word[g]                  = ZERO16;
                status_word[g][ST_INT_LSB +: 8] = res_int_r[g];
                status_word[g][ST_EXT_LSB +: 4] = res_ext_r[g];
                status_word[g][ST_RUN]          = !ctrl_r[CTL_STOP_LSB + g];
                status_word[g][ST_CMP]          = cmp_r[g];
                status_word[g][ST_OVF]          = ovf_r[g];
                status_word[g][ST_SVERR]        = sverr_r[g];
            end
        end
    endgenerate

    // readback and output mux
    always_comb begin
        rdata_nxt = ZERO16;

        if (rd) begin
            if (addr < ADDR_STATUS_BASE) begin
                rdata_nxt = addr[0] ? count_r[addr[2:1]][31:16]
                                    : count_r[addr[2:1]][15:0];
            end else if (addr < ADDR_CTRL) begin
                rdata_nxt = status_word[addr[1:0]];
            end else begin
                case (addr)
                    ADDR_CTRL:     rdata_nxt = ctrl_r;
                    ADDR_FORCE:    rdata_nxt = force_r;
                    ADDR_SETUP:    rdata_nxt = setup_r;
                    ADDR_TABLE_LO: rdata_nxt = tlo_r;
                    ADDR_TABLE_HI: rdata_nxt = thi_r;
                    default:       rdata_nxt = ZERO16;
                endcase
            end
        end
    end

    // forcing only adds ON; a 0 leaves the comparison pattern alone
    always_comb begin
        for (int i = 0; i < NUM_CNT; i++) begin
            ext_out_nxt[i] = res_ext_r[i][i] ||
                             (force_r[FRC_EN] && force_r[i]);
        end
    end

    // pin synchronisers: the first stage is read only by the second
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            enc_s1_r <= '0;
            enc_s2_r <= '0;
            enc_s3_r <= '0;
        end else begin
            enc_s1_r <= enc_s1_nxt;
            enc_s2_r <= enc_s1_r;
            enc_s3_r <= enc_s2_r;
        end
    end

    // software-visible words
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_r  <= ZERO16;
            force_r <= ZERO16;
            setup_r <= ZERO16;
            tlo_r   <= ZERO16;
            thi_r   <= ZERO16;
        end else begin
            ctrl_r  <= ctrl_nxt;
            force_r <= force_nxt;
            setup_r <= setup_nxt;
            tlo_r   <= tlo_nxt;
            thi_r   <= thi_nxt;
        end
    end

    // outputs come straight from these two registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata   <= ZERO16;
            ext_out <= 4'h0;
        end else begin
            rdata   <= rdata_nxt;
            ext_out <= ext_out_nxt;
        end
    end

    // per-counter state
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tvalid_r  <= 4'h0;
            cmp_r     <= 4'h0;
            ovf_r     <= 4'h0;
            sverr_r   <= 4'h0;
            for (int i = 0; i < NUM_CNT; i++) begin
                count_r[i]   <= ZERO32;
                target_r[i]  <= ZERO32;
                intp_r[i]    <= 8'h00;
                extp_r[i]    <= 4'h0;
                res_int_r[i] <= 8'h00;
                res_ext_r[i] <= 4'h0;
            end
        end else begin
            tvalid_r  <= tvalid_nxt;
            cmp_r     <= cmp_nxt;
            ovf_r     <= ovf_nxt;
            sverr_r   <= sverr_nxt;
            for (int i = 0; i < NUM_CNT; i++) begin
                count_r[i]   <= count_nxt[i];
                target_r[i]  <= target_nxt[i];
                intp_r[i]    <= intp_nxt[i];
                extp_r[i]    <= extp_nxt[i];
                res_int_r[i] <= res_int_nxt[i];
                res_ext_r[i] <= res_ext_nxt[i];
            end
        end
    end
endmodule : qhsc_top
